// ===== logic/adcsro_consts.svh
// constants of the converter serial readout port
`ifndef ADCSRO_CONSTS_SVH
`define ADCSRO_CONSTS_SVH
`define ADCSRO_WORD_BITS 24
`define ADCSRO_FIFO_DEPTH 8
`define ADCSRO_POS_LIM 26'sh07FFFFF
`define ADCSRO_NEG_LIM 26'sh3800000
`define ADCSRO_POS_CODE 24'h7FFFFF
`define ADCSRO_NEG_CODE 24'h800000
`define ADCSRO_STEP_SETTLE 6'h37
`define ADCSRO_WB_SETTLE_00 14'h36ED
`define ADCSRO_WB_SETTLE_01 14'h1B79
`define ADCSRO_WB_SETTLE_10 14'h0DBF
`define ADCSRO_WB_SETTLE_11 14'h06E2
`define ADCSRO_LL_SETTLE_00 14'h0226
`define ADCSRO_LL_SETTLE_01 14'h0126
`define ADCSRO_LL_SETTLE_10 14'h00A6
`define ADCSRO_LL_SETTLE_11 14'h006E
`define ADCSRO_PERIOD_00 14'h0100
`define ADCSRO_PERIOD_01 14'h0080
`define ADCSRO_PERIOD_10 14'h0040
`define ADCSRO_PERIOD_11 14'h0020
`define ADCSRO_CFG_RST 7'h00
`endif

// ===== logic/adcsro_pkg.sv
// types of the converter serial readout port
package adcsro_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_SETTLE, PH_RUN} adcsro_phase_type;
  typedef struct packed {
    logic swing_se;
    logic sclk_ext;
    logic [1:0] rate;
    logic wb;
    logic scs;
    logic spare;
  } adcsro_cfg_type;
  typedef struct packed {
    logic otr;
    logic [23:0] code;
  } adcsro_word_type;
  typedef struct packed {
    adcsro_phase_type phase;
    adcsro_cfg_type cfg_s1;
    adcsro_cfg_type cfg_s2;
    adcsro_cfg_type cfg;
    logic [2:0] start_s;
    logic [1:0] cs_s;
    logic [2:0] sck_s;
    logic [13:0] settle;
    logic [13:0] per;
    logic [5:0] step;
    logic [23:0] sh;
    logic [4:0] left;
    logic busy;
    logic sclk;
    logic sclk_n;
    logic sclk_oe;
    logic sclk_n_oe;
    logic dout;
    logic dout_n;
    logic dout_oe;
    logic rdy;
    logic rdy_n;
    logic otr;
    logic full;
  } adcsro_state_type;
endpackage : adcsro_pkg

// ===== logic/adcsro_port.sv
// serial readout port with its word buffer
`timescale 1ns/1ps
`include "adcsro_consts.svh"

module adcsro_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } adcsro_fifo_state_type;
  localparam adcsro_fifo_state_type FIFO_RST = '{mem: '0, wp: '0, rp: '0, cnt: '0, rdy: 1'b1};

  adcsro_fifo_state_type q;
  adcsro_fifo_state_type n;
  logic push;
  logic pop;

  always_comb begin
    n = q;
    push = in_valid & q.rdy;
    pop = out_ready & (q.cnt != '0);
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end else begin
      if (push) begin
        n.mem[q.wp] = in_data;
        n.wp = AW'(q.wp + 1'b1);
      end
      if (pop) begin
        n.rp = AW'(q.rp + 1'b1);
      end
      if (push && !pop) begin
        n.cnt = (AW+1)'(q.cnt + 1'b1);
      end else if (pop && !push) begin
        n.cnt = (AW+1)'(q.cnt - 1'b1);
      end
    end
    // ready is registered from the next count so a full buffer stalls the source exactly
    n.rdy = (n.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= FIFO_RST;
    end else begin
      q <= n;
    end
  end

  assign in_ready = q.rdy;
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_fifo_full_stalls;
    (q.cnt == (AW+1)'(DEPTH)) |-> !in_ready;
  endproperty
  a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("fifo full but ready");

  property p_fifo_count;
    (!flush && in_valid && in_ready && !out_ready) |=> (q.cnt == (AW+1)'($past(q.cnt) + 1'b1));
  endproperty
  a_fifo_count: assert property (p_fifo_count) else $error("fifo count did not grow");
endmodule : adcsro_fifo

module adcsro_port
  import adcsro_pkg::*;
#(
  parameter int WB_SETTLE_00 = `ADCSRO_WB_SETTLE_00
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic START,
  input wire logic SWING_SEL,
  input wire logic SCLK_SRC_SEL,
  input wire logic CS_N,
  input wire logic [1:0] RATE_SELECT,
  input wire logic FAST_FILTER_CONFIG,
  input wire logic FILTER_PATH_SELECT,
  input wire logic FILT_VALID,
  input wire logic [25:0] FILT_DATA,
  output logic FILT_READY,
  input wire logic SCLK_IN,
  output logic SCLK_OUT,
  output logic SCLK_OE,
  output logic SCLK_N_OUT,
  output logic SCLK_N_OE,
  output logic DOUT,
  output logic DOUT_N,
  output logic DOUT_OE,
  output logic CONVERSION_READY,
  output logic CONVERSION_READY_N,
  output logic OUT_OF_RANGE_FLAG,
  output logic FULL_SETTLE
);
  localparam adcsro_state_type ST_RST = '{phase: PH_IDLE, cfg_s1: `ADCSRO_CFG_RST, cfg_s2: `ADCSRO_CFG_RST,
    cfg: `ADCSRO_CFG_RST, rdy_n: 1'b1, sclk_n: 1'b1, default: '0};

  adcsro_state_type q;
  adcsro_state_type n;
  adcsro_word_type fin_word;
  adcsro_word_type fout_word;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_flush;
  logic start_edge;
  logic ext;
  logic cs_off;
  logic shift_now;
  logic signed [25:0] fin;

  // settling length in master clocks for a latched configuration
  function automatic logic [13:0] settle_len(input adcsro_cfg_type c);
    logic [13:0] r;
    r = `ADCSRO_LL_SETTLE_00;
    if (c.wb) begin
      unique case (c.rate)
        2'h0: r = 14'(WB_SETTLE_00);
        2'h1: r = `ADCSRO_WB_SETTLE_01;
        2'h2: r = `ADCSRO_WB_SETTLE_10;
        2'h3: r = `ADCSRO_WB_SETTLE_11;
      endcase
    end else begin
      unique case (c.rate)
        2'h0: r = `ADCSRO_LL_SETTLE_00;
        2'h1: r = `ADCSRO_LL_SETTLE_01;
        2'h2: r = `ADCSRO_LL_SETTLE_10;
        2'h3: r = `ADCSRO_LL_SETTLE_11;
      endcase
    end
    return r;
  endfunction : settle_len

  // sample period; single-cycle settling runs at its settling time
  function automatic logic [13:0] period_len(input adcsro_cfg_type c);
    logic [13:0] r;
    r = `ADCSRO_PERIOD_00;
    if (c.scs) begin
      r = settle_len(c);
    end else begin
      unique case (c.rate)
        2'h0: r = `ADCSRO_PERIOD_00;
        2'h1: r = `ADCSRO_PERIOD_01;
        2'h2: r = `ADCSRO_PERIOD_10;
        2'h3: r = `ADCSRO_PERIOD_11;
      endcase
    end
    return r;
  endfunction : period_len

  always_comb begin
    fin = FILT_DATA;
    fin_word.otr = 1'b0;
    fin_word.code = fin[23:0];
    if (fin > `ADCSRO_POS_LIM) begin
      fin_word.otr = 1'b1;
      fin_word.code = `ADCSRO_POS_CODE;
    end else if (fin < `ADCSRO_NEG_LIM) begin
      fin_word.otr = 1'b1;
      fin_word.code = `ADCSRO_NEG_CODE;
    end
  end

  assign fifo_flush = (q.phase != PH_RUN) | start_edge;

  adcsro_fifo #(.WIDTH(`ADCSRO_WORD_BITS + 1), .DEPTH(`ADCSRO_FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .flush(fifo_flush),
    .in_valid(FILT_VALID),
    .in_data(fin_word),
    .in_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fout_word)
  );

  assign start_edge = q.start_s[1] & ~q.start_s[2];
  assign ext = q.cfg.swing_se & q.cfg.sclk_ext;
  assign cs_off = q.cfg.swing_se & q.cs_s[1];
  assign shift_now = ext ? (~q.sck_s[1] & q.sck_s[2]) : q.sclk;

  always_comb begin
    n = q;
    fifo_pop = 1'b0;
    n.rdy = 1'b0;
    n.start_s = {q.start_s[1:0], START};
    n.cs_s = {q.cs_s[0], CS_N};
    n.sck_s = {q.sck_s[1:0], SCLK_IN};
    n.cfg_s1 = '{swing_se: SWING_SEL, sclk_ext: SCLK_SRC_SEL, rate: RATE_SELECT,
      wb: FAST_FILTER_CONFIG & FILTER_PATH_SELECT, scs: ~FAST_FILTER_CONFIG, spare: 1'b0};
    // fast filter low forces single-cycle path
    n.cfg_s2 = q.cfg_s1;
    // free-running shift clock, half the master rate
    n.sclk = ~q.sclk;
    if (q.busy && shift_now) begin
      if (q.left == 5'h00) begin
        n.busy = 1'b0;
      end else begin
        n.dout = q.sh[22];
        n.sh = {q.sh[22:0], 1'b0};
        n.left = 5'(q.left - 1'b1);
      end
    end
    unique case (q.phase)
      PH_IDLE: begin
      end
      PH_SETTLE: begin
        if (q.settle == 14'h0000) begin
          n.phase = PH_RUN;
          n.per = 14'h0000;
        end else begin
          n.settle = 14'(q.settle - 1'b1);
        end
      end
      PH_RUN: begin
        if (q.per == 14'h0000) begin
          // one ready per period
          // a start in the same cycle wins, so no word is popped into a flush
          if (fifo_valid && !q.busy && !cs_off && !start_edge) begin
            fifo_pop = 1'b1;
            n.rdy = 1'b1;
            n.sh = fout_word.code;
            n.dout = fout_word.code[23];
            n.left = 5'(`ADCSRO_WORD_BITS - 1);
            n.busy = 1'b1;
            n.otr = fout_word.otr;
            // count ready cycles to full settle
            if (q.step != `ADCSRO_STEP_SETTLE) begin
              n.step = 6'(q.step + 1'b1);
            end
            n.per = 14'(period_len(q.cfg) - 1'b1);
          end
        end else begin
          n.per = 14'(q.per - 1'b1);
        end
      end
    endcase
    n.full = q.cfg.wb & (n.step == `ADCSRO_STEP_SETTLE);
    if (cs_off) begin
      n.busy = 1'b0;
      n.sh = '0;
      n.left = '0;
      n.dout = 1'b0;
    end
    if (start_edge) begin
      n.cfg = q.cfg_s2;
      n.phase = PH_SETTLE;
      n.settle = 14'(settle_len(q.cfg_s2) - 1'b1);
      n.busy = 1'b0;
      n.rdy = 1'b0;
      n.step = '0;
      n.full = 1'b0;
    end
    n.dout_n = ~n.dout;
    n.rdy_n = ~n.rdy;
    n.dout_oe = ~cs_off;
    n.sclk_oe = ~ext & ~cs_off;
    n.sclk_n_oe = ext | ~cs_off;
    n.sclk_n = ext ? 1'b0 : ~n.sclk;
  end

  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign SCLK_OUT = q.sclk;
  assign SCLK_OE = q.sclk_oe;
  assign SCLK_N_OUT = q.sclk_n;
  assign SCLK_N_OE = q.sclk_n_oe;
  assign DOUT = q.dout;
  assign DOUT_N = q.dout_n;
  assign DOUT_OE = q.dout_oe;
  assign CONVERSION_READY = q.rdy;
  assign CONVERSION_READY_N = q.rdy_n;
  assign OUT_OF_RANGE_FLAG = q.otr;
  assign FULL_SETTLE = q.full;
  assign FILT_READY = fifo_ready;

  default clocking cbt @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  property p_otr_at_ready;
    $changed(OUT_OF_RANGE_FLAG) |-> CONVERSION_READY;
  endproperty
  a_otr_at_ready: assert property (p_otr_at_ready) else $error("range flag moved without ready");

  property p_cs_floats;
    (q.cfg.swing_se && q.cs_s[1] && !start_edge) |=> (!DOUT_OE && !CONVERSION_READY_N == CONVERSION_READY);
  endproperty
  a_cs_floats: assert property (p_cs_floats) else $error("data pins driven with chip select high");

  property p_ready_pair;
    CONVERSION_READY_N == !CONVERSION_READY;
  endproperty
  a_ready_pair: assert property (p_ready_pair) else $error("ready pair not complementary");

  property p_free_clock;
    (!q.cfg.swing_se && !start_edge) |=> (SCLK_OUT != $past(SCLK_OUT)) && SCLK_OE && (SCLK_N_OUT == !SCLK_OUT);
  endproperty
  a_free_clock: assert property (p_free_clock) else $error("internal shift clock not running");

  property p_ext_low;
    (ext && !start_edge) |=> (!SCLK_OE && SCLK_N_OE && !SCLK_N_OUT);
  endproperty
  a_ext_low: assert property (p_ext_low) else $error("complement clock not held low");

  property p_settle_hold;
    start_edge |=> !CONVERSION_READY [*8];
  endproperty
  a_settle_hold: assert property (p_settle_hold) else $error("ready during settling");

  property p_msb_first;
    fifo_pop |=> (DOUT == $past(fout_word.code[23])) && CONVERSION_READY;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not the msb");

  property p_clip;
    (fin > `ADCSRO_POS_LIM) |-> (fin_word.code == `ADCSRO_POS_CODE) && fin_word.otr;
  endproperty
  a_clip: assert property (p_clip) else $error("positive overrange not clipped");

  property p_ready_word;
    CONVERSION_READY |-> $past(fifo_valid) && (q.phase == PH_RUN);
  endproperty
  a_ready_word: assert property (p_ready_word) else $error("ready without a word");
endmodule : adcsro_port

// ===== testbench/adcsro_host.sv
// host model that receives the serial result words
`timescale 1ns/1ps
module adcsro_host (
  input wire logic clk,
  input wire logic ext,
  input wire logic rdy,
  input wire logic otr,
  input wire logic sclk,
  input wire logic dout,
  output logic sclk_in,
  output logic got,
  output logic [24:0] word
);
  int n;
  int t;
  logic on;
  logic tail;
  logic [24:0] sh;
  initial begin
    {on, tail, sh, sclk_in, got, word} = '0;
    n = 0;
    t = 0;
  end
  always @(posedge clk) begin
    got <= 1'b0;
    if (rdy) begin
      on = 1'b1;
      n = 0;
      t = 0;
      sh[24] = otr;
    end else begin
      t = t + 1;
    end
    // sample on the rising half, msb first
    if (on && (ext ? (t == 10 && !sclk_in) : sclk)) begin
      sh[23 - n] = dout;
      n = n + 1;
      if (n == 24) begin
        on = 1'b0;
        tail = 1'b1;
        got <= 1'b1;
        word <= sh;
      end
    end
    // host clock runs only inside a word, slow enough for the synchroniser
    // the last rise and fall let the port finish its word, then the clock stands low
    if (ext && (on || tail) && t == 10) begin
      if (!on && sclk_in) tail = 1'b0;
      sclk_in <= ~sclk_in;
      t = 0;
    end
  end
endmodule : adcsro_host

// ===== testbench/adcsro_port_test.sv
// self-checking bench of the serial readout port
`timescale 1ns/1ps
module adcsro_port_test;
  localparam int SET = 200;
  logic clk, rst, start, swing, src, cs_n, ffc, fps, fv, sck_in, got;
  logic fr, so, soe, sno, snoe, dout, doutn, doe, rdy, rdyn, otr, full, feed_en;
  logic [1:0] rate;
  logic [25:0] fd;
  logic [24:0] word;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [25:0] feed_q[$];
  logic [24:0] exp_q[$];

  adcsro_port #(.WB_SETTLE_00(SET)) i_dut (.CLK_SYS(clk), .SYS_RST(rst), .START(start), .SWING_SEL(swing),
    .SCLK_SRC_SEL(src), .CS_N(cs_n), .RATE_SELECT(rate), .FAST_FILTER_CONFIG(ffc), .FILTER_PATH_SELECT(fps),
    .FILT_VALID(fv), .FILT_DATA(fd), .FILT_READY(fr), .SCLK_IN(sck_in), .SCLK_OUT(so), .SCLK_OE(soe),
    .SCLK_N_OUT(sno), .SCLK_N_OE(snoe), .DOUT(dout), .DOUT_N(doutn), .DOUT_OE(doe),
    .CONVERSION_READY(rdy), .CONVERSION_READY_N(rdyn), .OUT_OF_RANGE_FLAG(otr), .FULL_SETTLE(full));
  adcsro_host i_host (.clk(clk), .ext(swing & src), .rdy(rdy), .otr(otr), .sclk(so), .dout(dout),
    .sclk_in(sck_in), .got(got), .word(word));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_w(string w, logic [24:0] e, logic [24:0] s);
    total_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", w, e, s);
    end
  endtask : check_w

  task automatic check_b(string w, logic e, logic s);
    total_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", w, e, s);
    end
  endtask : check_b

  task automatic check_n(string w, int lo, int hi, int s);
    total_checks++;
    if (s < lo || s > hi) begin
      n_mismatch++;
      $display("[ERR] %s expected %0d..%0d seen %0d", w, lo, hi, s);
    end
  endtask : check_n

  function automatic logic [24:0] exp_of(logic signed [25:0] v);
    if (v > 26'sh07FFFFF) return {1'b1, 24'h7FFFFF};
    if (v < 26'sh3800000) return {1'b1, 24'h800000};
    return {1'b0, v[23:0]};
  endfunction : exp_of

  task automatic push(logic [25:0] v);
    feed_q.push_back(v);
    exp_q.push_back(exp_of(v));
  endtask : push

  // feeder keeps valid up while words wait and feed_en is set, holds data until taken
  always @(posedge clk) begin
    if (fv && fr) void'(feed_q.pop_front());
    fv <= feed_en && feed_q.size() > 0;
    fd <= feed_q.size() > 0 ? feed_q[0] : 26'h0000000;
  end

  always @(posedge clk) if (got) begin
    check_w("word", exp_q.size() > 0 ? exp_q.pop_front() : 25'hX, word);
  end

  always @(negedge clk) if (!rst) begin
    check_b("rdy_n", ~rdy, rdyn);
    if (doe) check_b("dout_n", ~dout, doutn);
  end

  task automatic begin_run(logic sw, logic sr, logic [1:0] r, logic f);
    @(posedge clk);
    feed_en <= 1'b0;
    swing <= sw;
    src <= sr;
    rate <= r;
    ffc <= f;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : begin_run

  task automatic drain;
    int i;
    for (i = 0; i < 40000 && exp_q.size() > 0; i++) @(posedge clk);
    if (i == 40000) begin
      n_mismatch++;
      $display("[ERR] drain expected 0 seen %0d", exp_q.size());
      complete_run();
    end
  endtask : drain

  // words offered while the port settles are dropped, so feeding starts at cycle en
  task automatic ready_gap(int en, int lo, int hi);
    int i;
    for (i = 0; i < hi + 6 && !rdy; i++) begin
      if (i == en) feed_en <= 1'b1;
      @(posedge clk);
    end
    check_n("ready delay", lo, hi, i);
  endtask : ready_gap

  task automatic feed_on;
    repeat (SET) @(posedge clk);
    feed_en <= 1'b1;
  endtask : feed_on

  task automatic s_wide;
    begin_run(1'b0, 1'b0, 2'b00, 1'b1);
    push(26'h0000001);
    push(26'h0000000);
    push(26'h3FFFFFF);
    push(26'h07FFFFF);
    push(26'h0900000);
    push(26'h0000002);
    push(26'h3000000);
    push(26'h3800000);
    ready_gap(SET - 4, SET - 1, SET + 1);
    drain();
    check_b("full_settle", 1'b0, full);
  endtask : s_wide

  task automatic s_latch_cs;
    int i;
    swing <= 1'b1;
    cs_n <= 1'b1;
    repeat (10) @(posedge clk);
    check_b("dout_oe", 1'b1, doe);
    begin_run(1'b1, 1'b0, 2'b00, 1'b1);
    check_b("dout_oe", 1'b0, doe);
    check_b("sclk_oe", 1'b0, soe);
    check_b("sclk_n_oe", 1'b0, snoe);
    for (i = 0; i < 12; i++) push(26'h0000100 + 26'(i));
    feed_on();
    repeat (100) @(posedge clk);
    check_b("filt_ready", 1'b0, fr);
    cs_n <= 1'b0;
    drain();
    check_b("dout_oe", 1'b1, doe);
  endtask : s_latch_cs

  task automatic s_ext;
    begin_run(1'b1, 1'b1, 2'b00, 1'b1);
    check_b("sclk_oe", 1'b0, soe);
    check_b("sclk_n", 1'b0, sno);
    check_b("sclk_n_oe", 1'b1, snoe);
    push(26'h0A5A5A5);
    push(26'h3C3C3C3);
    feed_on();
    drain();
  endtask : s_ext

  task automatic s_diff;
    cs_n <= 1'b1;
    begin_run(1'b0, 1'b1, 2'b00, 1'b1);
    check_b("dout_oe", 1'b1, doe);
    check_b("sclk_oe", 1'b1, soe);
    push(26'h0123456);
    push(26'h3FEDCBA);
    feed_on();
    drain();
    cs_n <= 1'b0;
  endtask : s_diff

  task automatic s_low_lat;
    begin_run(1'b0, 1'b0, 2'b11, 1'b0);
    push(26'h0000010);
    push(26'h0000020);
    push(26'h0000030);
    ready_gap(106, 109, 111);
    @(posedge clk);
    ready_gap(-1, 108, 112);
    drain();
    check_b("full_settle", 1'b0, full);
  endtask : s_low_lat

  task automatic s_settle55;
    int i;
    begin_run(1'b0, 1'b0, 2'b00, 1'b1);
    for (i = 0; i < 54; i++) push(26'h0000400);
    feed_on();
    drain();
    check_b("full_settle", 1'b0, full);
    push(26'h0000400);
    drain();
    check_b("full_settle", 1'b1, full);
  endtask : s_settle55

  initial begin
    {start, swing, src, cs_n, fv, rate, fd, feed_en} = '0;
    {rst, ffc, fps} = 3'b111;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check_b("rdy_n", 1'b1, rdyn);
    check_b("otr", 1'b0, otr);
    s_wide();
    s_latch_cs();
    s_ext();
    s_diff();
    s_low_lat();
    s_settle55();
    complete_run();
  end
endmodule : adcsro_port_test
